// ===== gpcm_map.svh
// Constants for the GPIO pin control matrix: register offsets, field
// positions, reset values and pin counts.
// Notes on behaviour
// (R1) Each pin offers seven drive configurations from input only to weak both ways.
// (R2) Each pin selects a CMOS or LVTTL input threshold.
// (R3) Input and output buffers each have their own enable beside the drive mode.
// (R4) A hold function latches pin output state for deep sleep.
// (R5) Each pin selects a slow output slew rate to cut EMI.
// (R6) During power-on and any reset every pin is disabled and undriven.
// (R7) A matrix picks GPIO, serial, sideband or auxiliary source per pin.
// (R8) Up to 20 pins; the two debug pins double as GPIO.
// (R9) A pin carrying an I2C line runs open drain.
// (R10) Each pin has a switch onto the shared analog buses.
// (R11) Hold state persists without the main clock in deep sleep.
// (R12) Drive mode is a 3-bit field; code zero is high-impedance and disabled.
`ifndef GPCM_MAP_SVH
`define GPCM_MAP_SVH
`define GPCM_NPINS 20
`define GPCM_OFF_OUT 12'h000
`define GPCM_OFF_IN 12'h004
`define GPCM_OFF_HOLD 12'h008
`define GPCM_OFF_DBG 12'h00C
`define GPCM_OFF_CFG0 12'h100
`define GPCM_CFG_STRIDE 12'h004
`define GPCM_F_DM_LO 0
`define GPCM_F_DM_HI 2
`define GPCM_F_IE 3
`define GPCM_F_OE 4
`define GPCM_F_LVTTL 5
`define GPCM_F_SLOW 6
`define GPCM_F_AMUX 7
`define GPCM_F_SEL_LO 8
`define GPCM_F_SEL_HI 9
`define GPCM_CFG_RST 32'h0000_0000
`define GPCM_PIN_SWDIO 18
`define GPCM_PIN_SWCLK 19
`endif

// ===== gpcm_pkg.sv
// Types for the GPIO pin control matrix.
// Assumes gpcm_map.svh for numeric constants.
package gpcm_pkg;
  typedef enum logic [2:0] {
    GPCM_DM_OFF, GPCM_DM_INPUT, GPCM_DM_WKUP_STDN, GPCM_DM_STUP_WKDN,
    GPCM_DM_OD_LOW, GPCM_DM_OD_HIGH, GPCM_DM_STRONG, GPCM_DM_WEAK
  } gpcm_drive_t;
  typedef enum logic [1:0] {
    GPCM_SRC_GPIO, GPCM_SRC_SERIAL, GPCM_SRC_SIDEBAND, GPCM_SRC_AUX
  } gpcm_src_t;
endpackage : gpcm_pkg

// ===== gpcm_pad_ctl.sv
// One pad's drive decoder: turns mode, source value and hold into pad controls.
// Assumes all inputs are registered on clk; outputs are registered.
`timescale 1ns/1ps
`default_nettype none
module gpcm_pad_ctl
  import gpcm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] mode,
  input wire logic oe_en,
  input wire logic val,
  input wire logic hold,
  output logic drv_hi_strong,
  output logic drv_hi_weak,
  output logic drv_lo_strong,
  output logic drv_lo_weak,
  output logic pad_oe_n
);
  typedef struct packed {
    logic hs;
    logic hw;
    logic ls;
    logic lw;
    logic oen;
  } gpcm_pad_t;
  gpcm_pad_t st, next_st;
  gpcm_drive_t dm;
  assign dm = gpcm_drive_t'(mode);
  always_comb begin
    next_st = st;
    if (!hold) begin // (R4)
      next_st = '{hs: 1'b0, hw: 1'b0, ls: 1'b0, lw: 1'b0, oen: 1'b1};
      if (oe_en) begin // (R3)
        case (dm) // (R1)
          GPCM_DM_WKUP_STDN: begin
            next_st.hw = val;
            next_st.ls = !val;
          end
          GPCM_DM_STUP_WKDN: begin
            next_st.hs = val;
            next_st.lw = !val;
          end
          GPCM_DM_OD_LOW: next_st.ls = !val;
          GPCM_DM_OD_HIGH: next_st.hs = val;
          GPCM_DM_STRONG: begin
            next_st.hs = val;
            next_st.ls = !val;
          end
          GPCM_DM_WEAK: begin
            next_st.hw = val;
            next_st.lw = !val;
          end
          default: ; // Off and input only never drive (R12)
        endcase
        next_st.oen = !(next_st.hs | next_st.ls);
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) st <= '{hs: 1'b0, hw: 1'b0, ls: 1'b0, lw: 1'b0, oen: 1'b1}; // (R6)
    else st <= next_st;
  end
  assign drv_hi_strong = st.hs;
  assign drv_hi_weak = st.hw;
  assign drv_lo_strong = st.ls;
  assign drv_lo_weak = st.lw;
  assign pad_oe_n = st.oen;
  chk_hold_freeze: assert property (@(posedge clk) disable iff (!resetn)
    hold && $past(hold) |-> $stable(st)) else $error("pad moved while held"); // (R4)
  chk_od_never_high: assert property (@(posedge clk) disable iff (!resetn)
    $past(!hold && oe_en && dm == GPCM_DM_OD_LOW) |-> !st.hs && !st.hw)
    else $error("open drain low drove high"); // (R1)
endmodule : gpcm_pad_ctl
`default_nettype wire

// ===== gpcm_top.sv
// GPIO pin control matrix: per-pin configuration over AXI4-Lite, source mux,
// input receivers and pad drive controls.
// Assumes pad inputs are asynchronous, outputs feed external pad cells.
`timescale 1ns/1ps
`default_nettype none
`include "gpcm_map.svh"
module gpcm_top
  import gpcm_pkg::*;
#(
  parameter int NPINS = `GPCM_NPINS
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPINS-1:0] src_serial,
  input wire logic [NPINS-1:0] src_serial_i2c,
  input wire logic [NPINS-1:0] src_sideband,
  input wire logic [NPINS-1:0] src_aux,
  input wire logic deep_sleep,
  input wire logic [NPINS-1:0] pad_in_cmos,
  input wire logic [NPINS-1:0] pad_in_lvttl,
  output logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pad_hi_strong,
  output logic [NPINS-1:0] pad_hi_weak,
  output logic [NPINS-1:0] pad_lo_strong,
  output logic [NPINS-1:0] pad_lo_weak,
  output logic [NPINS-1:0] pad_oe_n,
  output logic [NPINS-1:0] pad_slow,
  output logic [NPINS-1:0] pad_amux_sw,
  output logic [NPINS-1:0] pad_hold,
  output logic debug_enable
);
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef struct packed {
    logic awr;
    logic wr;
    logic [11:0] aw;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic awrdy;
    logic wrdy;
    logic ardy;
    logic [NPINS-1:0] out;
    logic [NPINS-1:0] hold;
    logic dbg;
    logic [NPINS-1:0][9:0] cfg;
    logic [NPINS-1:0] s1;
    logic [NPINS-1:0] s2;
    logic [NPINS-1:0] s1l;
    logic [NPINS-1:0] s2l;
    logic [NPINS-1:0] ival;
    logic [NPINS-1:0] slow;
    logic [NPINS-1:0] amux;
    logic [NPINS-1:0] hold_q;
  } gpcm_state_t;
  gpcm_state_t st, next_st;
  logic [NPINS-1:0] dr_val, dr_oe;
  logic [NPINS-1:0][2:0] dr_mode;

  // Maps a config offset to a pin index; returns NPINS when unmapped
  function automatic int unsigned cfg_index(input logic [11:0] a);
    int unsigned i;
    i = NPINS;
    if (a >= `GPCM_OFF_CFG0 && a[1:0] == 2'h0 &&
        32'(a - `GPCM_OFF_CFG0) / 32'(`GPCM_CFG_STRIDE) < NPINS) begin
      i = 32'(a - `GPCM_OFF_CFG0) / 32'(`GPCM_CFG_STRIDE);
    end
    return i;
  endfunction : cfg_index

  function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction : bmerge

  always_comb begin
    int unsigned wi;
    int unsigned ri;
    logic [31:0] tmp;
    wi = 0;
    ri = 0;
    tmp = '0;
    next_st = st;
    // Write address and data taken in either order
    if (s_axi_awvalid && st.awrdy) begin
      next_st.awr = 1'b1;
      next_st.aw = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wrdy) begin
      next_st.wr = 1'b1;
      next_st.wd = s_axi_wdata;
      next_st.ws = s_axi_wstrb;
    end
    if (st.awr && st.wr && !st.bv) begin
      next_st.awr = 1'b0;
      next_st.wr = 1'b0;
      next_st.bv = 1'b1;
      next_st.br = RESP_OK;
      wi = cfg_index(st.aw);
      if (st.aw == `GPCM_OFF_OUT) begin
        tmp = bmerge(32'(st.out), st.wd, st.ws);
        next_st.out = tmp[NPINS-1:0];
      end else if (st.aw == `GPCM_OFF_HOLD) begin
        tmp = bmerge(32'(st.hold), st.wd, st.ws);
        next_st.hold = tmp[NPINS-1:0];
      end else if (st.aw == `GPCM_OFF_DBG) begin
        if (st.ws[0]) next_st.dbg = st.wd[0]; // (R8)
      end else if (st.aw == `GPCM_OFF_IN) begin
        next_st.br = RESP_OK;
      end else if (wi < NPINS) begin
        tmp = bmerge(32'(st.cfg[wi]), st.wd, st.ws);
        next_st.cfg[wi] = tmp[9:0]; // (R7)
      end else begin
        next_st.br = RESP_ERR;
      end
    end
    if (st.bv && s_axi_bready) next_st.bv = 1'b0;
    if (s_axi_arvalid && st.ardy) begin
      next_st.rv = 1'b1;
      next_st.rr = RESP_OK;
      ri = cfg_index(s_axi_araddr);
      if (s_axi_araddr == `GPCM_OFF_OUT) next_st.rd = 32'(st.out);
      else if (s_axi_araddr == `GPCM_OFF_IN) next_st.rd = 32'(st.ival);
      else if (s_axi_araddr == `GPCM_OFF_HOLD) next_st.rd = 32'(st.hold);
      else if (s_axi_araddr == `GPCM_OFF_DBG) next_st.rd = 32'(st.dbg);
      else if (ri < NPINS) next_st.rd = 32'(st.cfg[ri]);
      else begin
        next_st.rd = '0;
        next_st.rr = RESP_ERR;
      end
    end else if (st.rv && s_axi_rready) begin
      next_st.rv = 1'b0;
    end
    // Ready flags registered so every bus output leaves a flop
    next_st.awrdy = !next_st.awr && !next_st.bv;
    next_st.wrdy = !next_st.wr && !next_st.bv;
    next_st.ardy = !next_st.rv;
    // Both receivers synced first; threshold picks after, so no raw pin feeds logic (R2)
    next_st.s1 = pad_in_cmos;
    next_st.s1l = pad_in_lvttl;
    for (int p = 0; p < NPINS; p++) begin
      next_st.ival[p] = (st.cfg[p][`GPCM_F_LVTTL] ? st.s2l[p] : st.s2[p]) & st.cfg[p][`GPCM_F_IE]; // (R2) (R3)
      // Held pins keep slew and switch state too (R4)
      if (!st.hold_q[p]) begin
        next_st.slow[p] = st.cfg[p][`GPCM_F_SLOW]; // (R5)
        next_st.amux[p] = st.cfg[p][`GPCM_F_AMUX]; // (R10)
      end
    end
    next_st.s2 = st.s1;
    next_st.s2l = st.s1l;
    // Hold latch is set by software or for as long as deep_sleep stays high (R11)
    next_st.hold_q = st.hold | {NPINS{deep_sleep}};
  end

  // Source mux per pin; the select field alone picks the source, debug state has no effect
  always_comb begin
    for (int p = 0; p < NPINS; p++) begin
      dr_mode[p] = st.cfg[p][`GPCM_F_DM_HI:`GPCM_F_DM_LO];
      dr_oe[p] = st.cfg[p][`GPCM_F_OE];
      case (gpcm_src_t'(st.cfg[p][`GPCM_F_SEL_HI:`GPCM_F_SEL_LO])) // (R7)
        GPCM_SRC_GPIO: dr_val[p] = st.out[p];
        GPCM_SRC_SERIAL: begin
          dr_val[p] = src_serial[p];
          // I2C lines forced to open drain low (R9)
          if (src_serial_i2c[p]) dr_mode[p] = 3'(GPCM_DM_OD_LOW);
        end
        GPCM_SRC_SIDEBAND: dr_val[p] = src_sideband[p];
        GPCM_SRC_AUX: dr_val[p] = src_aux[p];
        default: dr_val[p] = st.out[p];
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0; // Config zero means every pin off (R6) (R12)
    end else begin
      st <= next_st;
    end
  end

  for (genvar g = 0; g < NPINS; g++) begin : g_pad
    gpcm_pad_ctl u_pad (
      .clk(clk),
      .resetn(resetn),
      .mode(dr_mode[g]),
      .oe_en(dr_oe[g]),
      .val(dr_val[g]),
      .hold(st.hold_q[g]),
      .drv_hi_strong(pad_hi_strong[g]),
      .drv_hi_weak(pad_hi_weak[g]),
      .drv_lo_strong(pad_lo_strong[g]),
      .drv_lo_weak(pad_lo_weak[g]),
      .pad_oe_n(pad_oe_n[g])
    );
  end

  assign s_axi_awready = st.awrdy;
  assign s_axi_wready = st.wrdy;
  assign s_axi_bvalid = st.bv;
  assign s_axi_bresp = st.br;
  assign s_axi_arready = st.ardy;
  assign s_axi_rvalid = st.rv;
  assign s_axi_rdata = st.rd;
  assign s_axi_rresp = st.rr;
  assign pin_in = st.ival;
  assign pad_slow = st.slow;
  assign pad_amux_sw = st.amux;
  assign pad_hold = st.hold_q;
  assign debug_enable = st.dbg;

  chk_reset_undriven: assert property (@(posedge clk)
    $rose(resetn) |-> pad_oe_n == '1 && pad_hi_strong == '0) else $error("pin driven after reset"); // (R6)
  chk_input_gate: assert property (@(posedge clk) disable iff (!resetn)
    !st.cfg[0][`GPCM_F_IE] && $past(!st.cfg[0][`GPCM_F_IE]) |=> !pin_in[0])
    else $error("input passed while disabled"); // (R3)
  chk_sleep_hold: assert property (@(posedge clk) disable iff (!resetn)
    deep_sleep |=> pad_hold == '1) else $error("deep sleep without hold"); // (R11)
  chk_slew_follow: assert property (@(posedge clk) disable iff (!resetn)
    !st.hold_q[0] |=> pad_slow[0] == $past(st.cfg[0][`GPCM_F_SLOW])) else $error("slew not applied"); // (R5)
  chk_amux_follow: assert property (@(posedge clk) disable iff (!resetn)
    !st.hold_q[1] |=> pad_amux_sw[1] == $past(st.cfg[1][`GPCM_F_AMUX])) else $error("switch not applied"); // (R10)
  chk_i2c_od: assert property (@(posedge clk) disable iff (!resetn)
    src_serial_i2c[3] && st.cfg[3][`GPCM_F_SEL_HI:`GPCM_F_SEL_LO] == 2'h1 && !st.hold_q[3]
    |=> !pad_hi_strong[3] && !pad_hi_weak[3]) else $error("i2c pin drove high"); // (R9)
  chk_write_resp: assert property (@(posedge clk) disable iff (!resetn)
    st.awr && st.wr |=> s_axi_bvalid) else $error("write not answered"); // (R7)
  chk_read_resp: assert property (@(posedge clk) disable iff (!resetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered"); // (R8)
  chk_write_refuse: assert property (@(posedge clk) disable iff (!resetn) // (R7)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  chk_oe_gate: assert property (@(posedge clk) disable iff (!resetn) // (R3)
    !st.hold_q[0] && !st.cfg[0][`GPCM_F_OE] |=> pad_oe_n[0] && !pad_hi_weak[0] && !pad_lo_weak[0])
    else $error("pin drove with output buffer off");
  chk_pin_held: assert property (@(posedge clk) disable iff (!resetn) // (R4)
    pad_hold[3] |=> $stable(pad_hi_strong[3]) && $stable(pad_lo_strong[3]))
    else $error("held pin changed drive");
  cov_write: cover property (@(posedge clk) s_axi_bvalid && s_axi_bready);
  cov_read: cover property (@(posedge clk) s_axi_rvalid && s_axi_rready);
  cov_drive: cover property (@(posedge clk) !pad_oe_n[0]);
  cov_hold: cover property (@(posedge clk) deep_sleep ##1 pad_hold[0]);
  cov_i2c_low: cover property (@(posedge clk) src_serial_i2c[3] && !pad_oe_n[3]);
endmodule : gpcm_top
`default_nettype wire

// ===== gpcm_board.sv
// Board-side model: resolves pad drive controls into a pin level for the receivers.
// Assumes drive controls come straight from the pad outputs of the pin matrix.
`timescale 1ns/1ps
`default_nettype none
module gpcm_board #(
  parameter int N = 20
)(
  input wire logic clk,
  input wire logic [N-1:0] hs,
  input wire logic [N-1:0] hw,
  input wire logic [N-1:0] ls,
  input wire logic [N-1:0] lw,
  input wire logic [N-1:0] ext_en,
  input wire logic [N-1:0] ext_val,
  input wire logic lv_flip,
  output logic [N-1:0] rx_cmos,
  output logic [N-1:0] rx_lvttl
);
  logic tog = 1'b0;
  logic [N-1:0] lvl;
  // Floating pins wander so a stale level never passes for a real one
  always @(posedge clk) tog <= !tog;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      lvl[i] = hs[i] ? 1'b1 : ls[i] ? 1'b0 : ext_en[i] ? ext_val[i] : hw[i] ? 1'b1 : lw[i] ? 1'b0 : tog;
    end
  end
  assign rx_cmos = lvl;
  // Flip lets the bench tell which receiver was chosen
  assign rx_lvttl = lvl ^ {N{lv_flip}};
endmodule : gpcm_board
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the pin matrix: AXI4-Lite master, board model, read queue.
// Assumes the map header, package and board model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "gpcm_map.svh"
module tb_top;
  import gpcm_pkg::*;
  localparam int N = `GPCM_NPINS;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, lv_flip = 1'b0, deep_sleep = 1'b0, dbg;
  logic [1:0] bresp, rresp, wr_resp;
  logic [N-1:0] src_serial = '0, src_i2c = '0, src_sb = '0, src_aux = '0, ext_en = '0, ext_val = '0;
  logic [N-1:0] rx_c, rx_l, pin_in, hs, hw, ls, lw, oe_n, slow, amux, hold;
  logic [33:0] exp_q[$];
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  gpcm_top #(.NPINS(N)) gpcm_top_i (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .src_serial(src_serial), .src_serial_i2c(src_i2c),
    .src_sideband(src_sb), .src_aux(src_aux), .deep_sleep(deep_sleep), .pad_in_cmos(rx_c), .pad_in_lvttl(rx_l),
    .pin_in(pin_in), .pad_hi_strong(hs), .pad_hi_weak(hw), .pad_lo_strong(ls), .pad_lo_weak(lw),
    .pad_oe_n(oe_n), .pad_slow(slow), .pad_amux_sw(amux), .pad_hold(hold), .debug_enable(dbg));
  gpcm_board #(.N(N)) gpcm_board_i (.clk(clk), .hs(hs), .hw(hw), .ls(ls), .lw(lw), .ext_en(ext_en),
    .ext_val(ext_val), .lv_flip(lv_flip), .rx_cmos(rx_c), .rx_lvttl(rx_l));

  always #20 clk = ~clk;

  // Expected drive as {hi_strong, hi_weak, lo_strong, lo_weak}
  function automatic logic [3:0] drv(input logic [2:0] m, input logic v);
    case (m)
      3'h2: drv = v ? 4'h4 : 4'h2;
      3'h3: drv = v ? 4'h8 : 4'h1;
      3'h4: drv = v ? 4'h0 : 4'h2;
      3'h5: drv = v ? 4'h8 : 4'h0;
      3'h6: drv = v ? 4'h8 : 4'h2;
      3'h7: drv = v ? 4'h4 : 4'h1;
      default: drv = 4'h0;
    endcase
  endfunction : drv

  task automatic cmp_val(input logic [33:0] act, input logic [33:0] ex);
    n_compared++;
    if (act !== ex) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, act, ex);
    end
  endtask : cmp_val

  task automatic cmp_pad(input int p, input logic [3:0] e, input logic sl, input logic am);
    cmp_val(34'({hs[p], hw[p], ls[p], lw[p], oe_n[p], slow[p], amux[p]}), 34'({e, !(e[3] | e[1]), sl, am}));
  endtask : cmp_pad

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_p;
    logic w_p;
    logic ta;
    logic tw;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_p || w_p) begin
      @(negedge clk);
      ta = aw_p && awready === 1'b1;
      tw = w_p && wready === 1'b1;
      @(posedge clk);
      if (ta) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (tw) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    wr_resp = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    @(posedge clk);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic finish_test;
    if (exp_q.size() != 0) failures++;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // Read results are matched in issue order
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      if (exp_q.size() == 0) failures++;
      else cmp_val({rresp, rdata}, exp_q.pop_front());
    end
  end

  // Generous ceiling; the sequence needs well under 2000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    int pins[2] = '{0, 19};
    int p;
    logic v;
    logic oe;
    logic [3:0] e;
    logic [N-1:0] lvm;
    logic [N-1:0] iem;
    logic [N-1:0] ex;
    logic [31:0] ov;
    void'($urandom(16));
    repeat (12) @(negedge clk);
    cmp_val(34'(oe_n), 34'({N{1'b1}}));
    cmp_val(34'(hs | hw | ls | lw | slow | amux | hold), 34'h0);
    @(posedge clk);
    resetn <= 1'b1;
    foreach (pins[k]) for (int m = 0; m < 8; m++) for (int b = 0; b < 4; b++) begin
      p = pins[k];
      v = b[0];
      oe = b[1];
      axi_wr(`GPCM_OFF_CFG0 + 12'(4 * p), {22'h0, 2'b00, oe, v, 1'b0, oe, 1'b1, 3'(m)}, 4'hF);
      axi_wr(`GPCM_OFF_OUT, 32'(v) << p, 4'hF);
      repeat (4) @(negedge clk);
      e = oe ? drv(3'(m), v) : 4'h0;
      cmp_pad(p, e, v, oe);
    end
    @(posedge clk);
    ext_val <= N'($urandom);
    ext_en <= '1;
    lv_flip <= 1'b1;
    for (int q = 0; q < N; q++) begin
      lvm[q] = (q % 3 == 0);
      iem[q] = !q[0];
      axi_wr(`GPCM_OFF_CFG0 + 12'(4 * q), {26'h0, lvm[q], 1'b0, iem[q], 3'h1}, 4'hF);
    end
    // Input register is read-only; this write must change nothing
    axi_wr(`GPCM_OFF_IN, 32'hFFFF_FFFF, 4'hF);
    cmp_val(34'(wr_resp), 34'h0);
    repeat (6) @(negedge clk);
    ex = (ext_val ^ lvm) & iem;
    cmp_val(34'(pin_in), 34'(ex));
    axi_rd(`GPCM_OFF_IN, {14'h0, ex});
    ext_en <= '0;
    for (int s = 0; s < 10; s++) begin
      @(posedge clk);
      src_serial <= N'($urandom);
      src_sb <= N'($urandom);
      src_aux <= N'($urandom);
      src_i2c <= (s % 5 == 4) ? '1 : '0;
      ov = $urandom;
      axi_wr(`GPCM_OFF_OUT, ov, 4'hF);
      axi_wr(`GPCM_OFF_CFG0 + 12'hC, {22'h0, (s % 5 == 4) ? 2'h1 : 2'(s % 5), 5'b00011, 3'h6}, 4'hF);
      repeat (4) @(negedge clk);
      case (s % 5)
        0: v = ov[3];
        2: v = src_sb[3];
        3: v = src_aux[3];
        default: v = src_serial[3];
      endcase
      cmp_pad(3, drv((s % 5 == 4) ? 3'h4 : 3'h6, v), 1'b0, 1'b0);
    end
    // Pin 3 back to GPIO strong so the output word reaches it
    axi_wr(`GPCM_OFF_CFG0 + 12'hC, 32'h0000_001E, 4'hF);
    axi_wr(`GPCM_OFF_OUT, 32'h8, 4'hF);
    deep_sleep <= 1'b1;
    repeat (3) @(negedge clk);
    axi_wr(`GPCM_OFF_OUT, 32'h0, 4'hF);
    repeat (4) @(negedge clk);
    cmp_pad(3, 4'h8, 1'b0, 1'b0);
    cmp_val(34'(hold[3]), 34'h1);
    @(posedge clk);
    deep_sleep <= 1'b0;
    repeat (5) @(negedge clk);
    cmp_pad(3, 4'h2, 1'b0, 1'b0);
    axi_wr(`GPCM_OFF_DBG, 32'h1, 4'hF);
    repeat (3) @(negedge clk);
    cmp_val(34'(dbg), 34'h1);
    axi_rd(`GPCM_OFF_DBG, 34'h1);
    axi_wr(`GPCM_OFF_CFG0 + 12'h04C, 32'h0000_03FF, 4'hF);
    axi_wr(`GPCM_OFF_CFG0 + 12'h04C, 32'h0000_0000, 4'h2);
    axi_rd(`GPCM_OFF_CFG0 + 12'h04C, 34'h0FF);
    axi_wr(12'h0F0, 32'h1, 4'hF);
    cmp_val(34'(wr_resp), 34'h2);
    axi_rd(12'h0F0, {2'b10, 32'h0});
    repeat (4) @(negedge clk);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
